// *** src/abs_rx_map.svh ***
// Clock, counts, scale, unit codes and timing constants of the absolute position receiver.
`ifndef ABS_RX_MAP_SVH
`define ABS_RX_MAP_SVH
`define CLK_MHZ          250
`define SAMPLE_DELAY_MS  10
`define SAMPLE_DELAY_CYC (`SAMPLE_DELAY_MS * 1000 * `CLK_MHZ)
`define MODE_TMO_MS      1000
`define REQ_TMO_MS       1000
`define RDY_TMO_MS       1000
`define RETRY_WAIT_MS    100
`define TOTAL_SLICES     19
`define DATA_SLICES      16
`define MAX_RETRIES      3
`define MM_SCALE         10
`define PULSE_UNIT       2'd3
`define MM_UNIT          2'd0
`endif

// *** src/abs_rx_pkg.sv ***
// Types of the absolute position receiver.
package abs_rx_pkg;
	typedef enum logic [2:0] {
		ST_IDLE, ST_MODE, ST_REQ, ST_SETTLE, ST_DROP, ST_CHECK, ST_WAIT
	} rx_state_t;
endpackage

// *** src/pos_fifo.sv ***
// Small flip-flop FIFO for received positions.
`timescale 1ns/1ps
`default_nettype none
module pos_fifo #(
	parameter int WIDTH = 32,
	parameter int DEPTH = 8
) (
	input  wire logic             clk,
	input  wire logic             rst_b,
	input  wire logic             in_valid,
	output logic                  in_ready,
	input  wire logic [WIDTH-1:0] in_data,
	output logic                  out_valid,
	input  wire logic             out_ready,
	output logic      [WIDTH-1:0] out_data
);
	localparam int AW = $clog2(DEPTH);
	logic [WIDTH-1:0] mem [DEPTH];
	logic [AW-1:0]    wp, rp, next_wp, next_rp;
	logic [AW:0]      cnt, next_cnt;
	logic             push, pop;
	assign in_ready  = (cnt != (AW+1)'(DEPTH));
	assign out_valid = (cnt != '0);
	assign out_data  = mem[rp];
	always_comb
	begin
		push     = in_valid && in_ready;
		pop      = out_valid && out_ready;
		next_wp  = push ? wp + 1'b1 : wp;
		next_rp  = pop ? rp + 1'b1 : rp;
		next_cnt = cnt + {{AW{1'b0}}, push} - {{AW{1'b0}}, pop};
	end
	always_ff @(posedge clk or negedge rst_b)
	begin
		if (!rst_b)
		begin
			wp  <= '0;
			rp  <= '0;
			cnt <= '0;
		end
		else
		begin
			wp  <= next_wp;
			rp  <= next_rp;
			cnt <= next_cnt;
		end
	end
	always_ff @(posedge clk)
	begin
		if (push)
			mem[wp] <= in_data;
	end
endmodule
`default_nettype wire

// *** src/absolute_position_receiver.sv ***
// Controller end that reads the absolute position from a servo amplifier.
`include "abs_rx_map.svh"
`timescale 1ns/1ps
`default_nettype none
// Contract
// - Transfer starts at power-up or run rising
// - Alarm or stop release restarts transfer
// - Checksum mismatch retries, three more times
// - Retries exhausted raises checksum error
// - Time mode, request, ready phases; error
// - Each step gives two bits, staged
// - Position shifted into one 32-bit register
// - Wait 10 ms before sampling bits
// - Non-pulse unit multiplies by constant K
// - Millimetre unit with K zero multiplies feed by ten
// - Nineteen two-bit receptions per transfer
// - Sixteen receptions carry position data
module absolute_position_receiver #(
	parameter int SAMPLE_CYC = `SAMPLE_DELAY_CYC,
	parameter int MODE_CYC   = `MODE_TMO_MS * 1000 * `CLK_MHZ,
	parameter int REQ_CYC    = `REQ_TMO_MS * 1000 * `CLK_MHZ,
	parameter int RDY_CYC    = `RDY_TMO_MS * 1000 * `CLK_MHZ,
	parameter int WAIT_CYC   = `RETRY_WAIT_MS * 1000 * `CLK_MHZ,
	parameter int DEPTH      = 8
) (
	input  wire logic        clk,
	input  wire logic        rst_b,
	input  wire logic        servo_enable,
	input  wire logic        run_state,
	input  wire logic        alarm_reset,
	input  wire logic        estop_release,
	input  wire logic [1:0]  unit_setting,
	input  wire logic [9:0]  scale_k,
	input  wire logic        data_bit0_in,
	input  wire logic        data_bit1_in,
	input  wire logic        send_ready_in,
	output logic             servo_enable_out,
	output logic             transfer_mode_out,
	output logic             position_request_out,
	output logic             link_error_out,
	output logic             sum_error_out,
	output logic             busy,
	output logic             pos_valid,
	input  wire logic        pos_ready,
	output logic [31:0]      pos_data
);
	logic [31:0] pos, next_pos;
	logic [5:0]  csum, next_csum;
	logic [5:0]  sum, next_sum;
	logic [1:0]  stage, next_stage;
	logic [4:0]  slice, next_slice;
	logic [1:0]  tries, next_tries;
	logic [31:0] tmr, next_tmr;
	logic        link_err, next_link_err, sum_err, next_sum_err;
	logic        run_q, se_q, pend, next_pend;
	logic        push, fifo_rdy;
	logic [31:0] scaled;
	abs_rx_pkg::rx_state_t st, next_st;

	logic start_ev;
	assign start_ev = (servo_enable && !se_q)
		|| (run_state && !run_q && servo_enable)
		|| alarm_reset || estop_release;

	// Non-pulse units are scaled by K; the millimetre case uses 10 when K is zero.
	always_comb
	begin
		if (unit_setting == `PULSE_UNIT)
			scaled = pos;
		else if (unit_setting == `MM_UNIT && scale_k == '0)
			scaled = 32'(pos * `MM_SCALE);
		else
			scaled = 32'(pos * {22'h0, scale_k});
	end

	always_comb
	begin
		next_st       = st;
		next_pos      = pos;
		next_csum     = csum;
		next_sum      = sum;
		next_stage    = stage;
		next_slice    = slice;
		next_tries    = tries;
		next_tmr      = tmr + 32'h1;
		next_link_err = link_err;
		next_sum_err  = sum_err;
		next_pend     = pend || start_ev;
		push          = 1'b0;
		case (st)
		abs_rx_pkg::ST_IDLE:
			if (next_pend && servo_enable)
			begin
				next_pend     = 1'b0;
				next_st       = abs_rx_pkg::ST_MODE;
				next_tmr      = '0;
				next_tries    = '0;
				next_slice    = '0;
				next_sum      = '0;
				next_link_err = 1'b0;
				next_sum_err  = 1'b0;
			end
		abs_rx_pkg::ST_MODE:
			// In mode the amplifier turns ready on to invite a request.
			if (send_ready_in)
			begin
				next_st  = abs_rx_pkg::ST_REQ;
				next_tmr = '0;
			end
			else if (tmr >= 32'(MODE_CYC))
			begin
				next_link_err = 1'b1;
				next_st       = abs_rx_pkg::ST_IDLE;
			end
		abs_rx_pkg::ST_REQ:
			if (!send_ready_in)
			begin
				next_st  = abs_rx_pkg::ST_SETTLE;
				next_tmr = '0;
			end
			else if (tmr >= 32'(REQ_CYC))
			begin
				next_link_err = 1'b1;
				next_st       = abs_rx_pkg::ST_IDLE;
			end
		abs_rx_pkg::ST_SETTLE:
			if (tmr >= 32'(SAMPLE_CYC))
			begin
				next_stage = {data_bit1_in, data_bit0_in};
				next_slice = slice + 5'd1;
				if (slice < 5'(`DATA_SLICES))
				begin
					next_pos = {next_stage, pos[31:2]};
					next_sum = sum + {4'h0, next_stage};
				end
				else
					next_csum = {next_stage, csum[5:2]};
				next_st  = abs_rx_pkg::ST_DROP;
				next_tmr = '0;
			end
		abs_rx_pkg::ST_DROP:
			if (send_ready_in)
			begin
				next_tmr = '0;
				if (slice == 5'(`TOTAL_SLICES))
					next_st = abs_rx_pkg::ST_CHECK;
				else
					next_st = abs_rx_pkg::ST_REQ;
			end
			else if (tmr >= 32'(RDY_CYC))
			begin
				next_link_err = 1'b1;
				next_st       = abs_rx_pkg::ST_IDLE;
			end
		abs_rx_pkg::ST_CHECK:
			if (csum == sum)
			begin
				if (fifo_rdy)
				begin
					push    = 1'b1;
					next_st = abs_rx_pkg::ST_IDLE;
				end
			end
			else if (tries == 2'(`MAX_RETRIES))
			begin
				next_sum_err = 1'b1;
				next_st      = abs_rx_pkg::ST_IDLE;
			end
			else
			begin
				next_tries = tries + 2'd1;
				next_st    = abs_rx_pkg::ST_WAIT;
				next_tmr   = '0;
			end
		abs_rx_pkg::ST_WAIT:
			if (tmr >= 32'(WAIT_CYC))
			begin
				next_st    = abs_rx_pkg::ST_MODE;
				next_slice = '0;
				next_sum   = '0;
				next_tmr   = '0;
			end
		default:
			next_st = abs_rx_pkg::ST_IDLE;
		endcase
	end

	always_ff @(posedge clk or negedge rst_b)
	begin
		if (!rst_b)
		begin
			st       <= abs_rx_pkg::ST_IDLE;
			pos      <= '0;
			csum     <= '0;
			sum      <= '0;
			stage    <= '0;
			slice    <= '0;
			tries    <= '0;
			tmr      <= '0;
			link_err <= 1'b0;
			sum_err  <= 1'b0;
			pend     <= 1'b0;
			run_q    <= 1'b0;
			se_q     <= 1'b0;
		end
		else
		begin
			st       <= next_st;
			pos      <= next_pos;
			csum     <= next_csum;
			sum      <= next_sum;
			stage    <= next_stage;
			slice    <= next_slice;
			tries    <= next_tries;
			tmr      <= next_tmr;
			link_err <= next_link_err;
			sum_err  <= next_sum_err;
			pend     <= next_pend;
			run_q    <= run_state;
			se_q     <= servo_enable;
		end
	end

	assign servo_enable_out     = servo_enable;
	assign transfer_mode_out    = (st != abs_rx_pkg::ST_IDLE)
		&& (st != abs_rx_pkg::ST_WAIT);
	// Request stays up through the settle wait and drops after sampling or on a request timeout.
	assign position_request_out = (st == abs_rx_pkg::ST_REQ)
		|| (st == abs_rx_pkg::ST_SETTLE);
	assign link_error_out       = link_err;
	assign sum_error_out        = sum_err;
	assign busy                 = (st != abs_rx_pkg::ST_IDLE);

	pos_fifo #(
		.WIDTH (32),
		.DEPTH (DEPTH)
	) u_pos_fifo (
		.clk       (clk),
		.rst_b     (rst_b),
		.in_valid  (push),
		.in_ready  (fifo_rdy),
		.in_data   (scaled),
		.out_valid (pos_valid),
		.out_ready (pos_ready),
		.out_data  (pos_data)
	);
endmodule
`default_nettype wire

// *** verif/amp_model.sv ***
// Servo amplifier model serving the position in two-bit slices.
`timescale 1ns/1ps
`default_nettype none
module amp_model (
	input  wire logic        clk,
	input  wire logic        rst_b,
	input  wire logic        transfer_mode_out,
	input  wire logic        position_request_out,
	input  wire logic [31:0] pos,
	input  wire logic        bad,
	input  wire logic        dead,
	output logic             send_ready_in,
	output logic             data_bit0_in,
	output logic             data_bit1_in,
	output logic [4:0]       slices,
	output logic [3:0]       xfers
);
	logic       m_q, r_q;
	logic [5:0] sum;
	logic [1:0] cur;
	always_comb
	begin
		sum = 6'(bad);
		for (int j = 0; j < 16; j++)
			sum = sum + 6'(pos[2*j +: 2]);
		cur = slices[4] ? sum[2*slices[1:0] +: 2] : pos[2*slices[3:0] +: 2];
	end
	// Lines not being read show the inverse, so a stale sample fails.
	assign {data_bit1_in, data_bit0_in} = send_ready_in ? ~cur : cur;
	always_ff @(posedge clk or negedge rst_b)
		if (!rst_b)
			{m_q, r_q, send_ready_in, slices, xfers} <= '0;
		else
		begin
			m_q <= transfer_mode_out;
			r_q <= position_request_out;
			send_ready_in <= transfer_mode_out && !dead
				&& !position_request_out;
			if (transfer_mode_out && !m_q)
				{slices, xfers} <= {5'h00, xfers + 4'h1};
			else if (r_q && !position_request_out)
				slices <= slices + 5'h01;
		end
endmodule
`default_nettype wire

// *** verif/absolute_position_receiver_monitor.sv ***
// Port assertions for the absolute position receiver.
`timescale 1ns/1ps
`default_nettype none
module absolute_position_receiver_monitor (
	input wire logic        clk,
	input wire logic        rst_b,
	input wire logic        send_ready_in,
	input wire logic        transfer_mode_out,
	input wire logic        position_request_out,
	input wire logic        link_error_out,
	input wire logic        sum_error_out,
	input wire logic        pos_valid,
	input wire logic        pos_ready,
	input wire logic [31:0] pos_data
);
	default clocking cb @(posedge clk);
	endclocking
	default disable iff (!rst_b);
	req_mode_a: assert property (
		position_request_out |-> transfer_mode_out) else $error("req w/o mode");
	req_hold_a: assert property (
		position_request_out && send_ready_in |-> ##1 position_request_out
		or ##[1:2] link_error_out) else $error("req dropped early");
	settle_a: assert property (
		$fell(send_ready_in) && position_request_out |-> position_request_out
		[*8] ##[1:40] !position_request_out) else $error("bad settle");
	ready_wait_a: assert property (
		transfer_mode_out && !position_request_out && !send_ready_in
		|-> ##[1:100] (send_ready_in || !transfer_mode_out)) else $error("hang");
	link_idle_a: assert property (
		$rose(link_error_out) |-> ##[0:2] !transfer_mode_out) else $error("link");
	err_clear_a: assert property (
		$rose(transfer_mode_out) |-> ##[0:2] !(link_error_out || sum_error_out))
		else $error("flags kept");
	sum_idle_a: assert property (
		$rose(sum_error_out) |-> ##[0:2] !transfer_mode_out) else $error("sum");
	fifo_hold_a: assert property (
		pos_valid && !pos_ready |=> pos_valid && $stable(pos_data))
		else $error("fifo output moved");
	cover property (pos_valid && pos_ready);
	cover property ($rose(sum_error_out));
	cover property ($rose(link_error_out));
endmodule
bind absolute_position_receiver absolute_position_receiver_monitor
	u_absolute_position_receiver_monitor (.*);
`default_nettype wire

// *** verif/absolute_position_receiver_tb_top.sv ***
// Self-checking bench for the absolute position receiver.
`timescale 1ns/1ps
`default_nettype none
module absolute_position_receiver_tb_top;
	typedef struct packed {
		logic [31:0] p;
		logic [1:0]  u;
		logic [9:0]  k;
		logic [3:0]  s;
		logic [31:0] e;
	} row_t;
	logic        clk, rst_b, servo_enable, run_state, alarm_reset, bad;
	logic        estop_release, pos_ready, dead, send_ready_in, busy;
	logic        transfer_mode_out, position_request_out, pos_valid;
	logic        link_error_out, sum_error_out, servo_enable_out;
	logic        data_bit0_in, data_bit1_in;
	logic [1:0]  unit_setting;
	logic [9:0]  scale_k;
	logic [31:0] pos_data, pos;
	logic [4:0]  slices;
	logic [3:0]  xfers;
	int          errors, n_compared;
	row_t        rows [4];
	absolute_position_receiver #(.SAMPLE_CYC(20), .MODE_CYC(40),
		.REQ_CYC(40), .RDY_CYC(40), .WAIT_CYC(20))
		u_absolute_position_receiver (.*);
	amp_model u_amp_model (.*);
	initial forever #2 clk = ~clk;
	task chk(input logic [31:0] g, input logic [31:0] x);
		n_compared++;
		errors += int'(g !== x);
		if (g !== x)
			$display("BAD t=%0t got %h exp %h", $time, g, x);
	endtask
	task end_sim;
		$display("errors %0d compared %0d", errors, n_compared);
		if (errors == 0 && n_compared > 0)
			$display("Testbench passed");
		else
			$display("Testbench failed");
		$finish;
	endtask
	// Condition b: 0 idle, 1 busy, 2 sum error, 3 link error, 4 position.
	task wt(input int b, input int lim);
		logic [4:0] v;
		for (int c = 0; c < lim; c++)
		begin
			@(negedge clk);
			v = {pos_valid, link_error_out, sum_error_out, busy, !busy};
			if (v[b] === 1'b1)
				return;
		end
		errors++;
		end_sim();
	endtask
	// Start bits are estop, alarm, run and servo; run and servo are levels.
	task kick(input logic [3:0] s, input int lim);
		@(posedge clk);
		{estop_release, alarm_reset, run_state, servo_enable} <= s;
		@(posedge clk);
		{estop_release, alarm_reset} <= 2'h0;
		wt(1, 10);
		wt(0, lim);
	endtask
	initial
	begin
		clk = 1'b0;
		{rst_b, servo_enable, run_state, alarm_reset, estop_release} = '0;
		{pos_ready, bad, dead, unit_setting, scale_k, pos} = '0;
		rows[0] = '{32'h1234_5678, 2'h3, 10'h005, 4'h1, 32'h1234_5678};
		rows[1] = '{32'h0000_0100, 2'h2, 10'h032, 4'h5, 32'h0000_3200};
		rows[2] = '{32'h0000_1234, 2'h0, 10'h000, 4'h9, 32'h0000_b608};
		rows[3] = '{32'hffff_fffe, 2'h1, 10'h3e8, 4'h3, 32'hffff_f830};
		repeat (12) @(posedge clk);
		rst_b <= 1'b1;
		@(negedge clk);
		chk(32'({transfer_mode_out, link_error_out, pos_valid}), 32'h0);
		// Results queue while pos_ready is low, then drain in order.
		foreach (rows[i])
		begin
			@(posedge clk);
			{pos, unit_setting, scale_k} <= {rows[i].p, rows[i].u, rows[i].k};
			kick(rows[i].s, 2000);
			chk(32'(slices), 32'h13);
		end
		foreach (rows[i])
		begin
			wt(4, 5);
			chk(pos_data, rows[i].e);
			@(posedge clk);
			pos_ready <= 1'b1;
			@(posedge clk);
			pos_ready <= 1'b0;
		end
		@(posedge clk);
		bad <= 1'b1;
		kick(4'h7, 6000);
		chk(32'({xfers, sum_error_out, pos_valid}), 32'h22);
		@(posedge clk);
		{bad, dead} <= 2'h1;
		kick(4'hb, 500);
		chk(32'({link_error_out, sum_error_out}), 32'h2);
		chk(32'({servo_enable_out, busy}), 32'h2);
		end_sim();
	end
endmodule
`default_nettype wire
